/* verilog/ata_defs.vh */
`ifndef ATA_DEFS_VH
`define ATA_DEFS_VH

// Register byte offsets.
`define ATA_REG_CTRL 8'h00
`define ATA_REG_STATUS 8'h04
`define ATA_REG_TXDATA 8'h08
`define ATA_REG_RXDATA 8'h0c
`define ATA_REG_ADDR 8'h10
`define ATA_REG_CTRLCODE 8'h14

// Control register fields.
`define ATA_CTRL_START 0
`define ATA_CTRL_OP_LO 1
`define ATA_CTRL_OP_HI 3
`define ATA_CTRL_LAST 4

// Status register fields.
`define ATA_ST_BUSY 0
`define ATA_ST_LOCAL 1
`define ATA_ST_RXVALID 2
`define ATA_ST_TXFULL 3
`define ATA_ST_PERR 4
`define ATA_ST_ACCERR 5
`define ATA_ST_CTRLFLAG 6
`define ATA_ST_MODE_LO 8
`define ATA_ST_MODE_HI 11

// Operations written to the control register.
`define ATA_OP_WRITE 3'h0
`define ATA_OP_PUNCH 3'h1
`define ATA_OP_WRCTL 3'h2
`define ATA_OP_READ 3'h3
`define ATA_OP_TAPE 3'h4
`define ATA_OP_RDCTL 3'h5

// Character codes.
`define ATA_CH_SI 7'h0f
`define ATA_CH_SO 7'h0e
`define ATA_CH_DC1 7'h11
`define ATA_CH_DC2 7'h12
`define ATA_CH_DC3 7'h13
`define ATA_CH_DC4 7'h14
`define ATA_CH_HT 7'h09
`define ATA_CH_CR 7'h0d
`define ATA_CH_E 7'h45
`define ATA_CH_L 7'h4c
`define ATA_CH_OPEN 7'h28
`define ATA_CH_CLOSE 7'h29
`define ATA_COL45_BIT 7'h40

// Timing.
`define ATA_CLK_HZ 125000000
`define ATA_RATE_110 110
`define ATA_RATE_150 150
`define ATA_RATE_200 200
`define ATA_RATE_300 300
`define ATA_BREAK_MS 200
`define ATA_WTO_LONG_MS 1800
`define ATA_WTO_SHORT_MS 1000
`define ATA_BREAK_CYC (`ATA_CLK_HZ / 1000 * `ATA_BREAK_MS)
`define ATA_WTO_LONG_CYC (`ATA_CLK_HZ / 1000 * `ATA_WTO_LONG_MS)
`define ATA_WTO_SHORT_CYC (`ATA_CLK_HZ / 1000 * `ATA_WTO_SHORT_MS)
`define ATA_FRAME_BITS 4'ha
`define ATA_FRAME_BITS_SLOW 4'hb
`define ATA_PART_UNIT 16'h03e8

`endif

/* verilog/ata_core.v */
// Summary of operation
// - Frame: start bit, seven code bits, parity bit, stop bit; ten bits at higher rates.
// - At 110 bps a second stop bit is added to each character.
// - Two rate switches pick 110, 150, 200 or 300 bits per second.
// - Characters carry even parity; the terminal sends and accepts even parity.
// - Control switch off: received control codes act and are not stored.
// - Control switch on: control codes are stored as column 4/5 equivalents.
// - Received tab never triggers an internal function; carriage return ends the read.
// - Write-control characters wait 1.8 s, or 1.0 s with interval switch on.
// - Manual reset input returns the adapter to idle alone.
// - Only one terminal, with its reader and punch, is served at once.
// - Each operation starts by sending the needed device on code.
// - Each operation ends by sending off codes to idle the terminal.
// - No reader-off code after tape reading; tape supplies DC3.
// - Each break toggles between online and local status.
// - In local status terminal activity is not passed to the processor.
// - Entering local prints an opening parenthesis, leaving it a closing one.
// - Entry prompt is E for a read, L for a read-control.
// - A prompt is sent on read and read-control requests; L replaces E when reload is needed.
// - Transfers stay inside the jumpered partition; privileged area needs its jumper.
// - A break is line low longer than a character, about 200 ms.
// - Codes: SI printer on, SO off, DC1 reader, DC2 punch on, DC4 off.
`timescale 1ns/1ps
`include "ata_defs.vh"

module ata_core #(
  parameter [31:0] DIV_110 = `ATA_CLK_HZ / `ATA_RATE_110,
  parameter [31:0] DIV_150 = `ATA_CLK_HZ / `ATA_RATE_150,
  parameter [31:0] DIV_200 = `ATA_CLK_HZ / `ATA_RATE_200,
  parameter [31:0] DIV_300 = `ATA_CLK_HZ / `ATA_RATE_300,
  parameter [31:0] BREAK_CYC = `ATA_BREAK_CYC,
  parameter [31:0] WTO_LONG_CYC = `ATA_WTO_LONG_CYC,
  parameter [31:0] WTO_SHORT_CYC = `ATA_WTO_SHORT_CYC
) (
  input wire clk_i, // System clock, 125 MHz.
  input wire rst_i, // Synchronous reset, active high.
  input wire wb_cyc_i, // Wishbone cycle.
  input wire wb_stb_i, // Wishbone strobe.
  input wire wb_we_i, // Wishbone write enable.
  input wire [7:0] wb_adr_i, // Wishbone byte address.
  input wire [3:0] wb_sel_i, // Wishbone byte selects.
  input wire [31:0] wb_dat_i, // Wishbone write data.
  output reg [31:0] wb_dat_o, // Wishbone read data.
  output reg wb_ack_o, // Wishbone acknowledge.
  input wire rxd_i, // Serial data from terminal, idle high.
  output reg txd_o, // Serial data to terminal, idle high.
  input wire ctrl_char_input_switch_i, // Store control codes instead of acting.
  input wire rate_select_hi_switch_i, // Bit rate switch one.
  input wire rate_select_lo_switch_i, // Bit rate switch two.
  input wire write_timeout_switch_i, // Short write-control timeout.
  input wire manual_reset_switch_i, // Momentary adapter reset.
  input wire [3:0] partition_size_jumpers_i, // Partition size in thousands.
  input wire privileged_access_jumper_i, // Allows privileged area access.
  input wire reload_needed_flag_i, // Program reload required.
  output reg local_o, // Terminal is in local status.
  output reg busy_o // Operation in progress.
);

  localparam [3:0] M0 = 4'h0;
  localparam [3:0] M1 = 4'h1;
  localparam [3:0] M2 = 4'h2;
  localparam [3:0] M3 = 4'h3;
  localparam [3:0] M4 = 4'h4;
  localparam [3:0] M6 = 4'h6;
  localparam [3:0] M7 = 4'h7;
  localparam [3:0] M8 = 4'h8;
  localparam [3:0] M9 = 4'h9;
  localparam [3:0] M10 = 4'ha;
  localparam [3:0] M12 = 4'hc;
  localparam [3:0] M13 = 4'hd;
  localparam [3:0] M14 = 4'he;

  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;
  localparam [1:0] RX_STOP = 2'h3;

  wire rst = rst_i | manual_reset_switch_i;

  reg [31:0] bit_div;
  wire slow = ~rate_select_hi_switch_i & ~rate_select_lo_switch_i;

  always @* begin
    case ({rate_select_hi_switch_i, rate_select_lo_switch_i})
      2'b00: bit_div = DIV_110;
      2'b01: bit_div = DIV_150;
      2'b11: bit_div = DIV_200;
      default: bit_div = DIV_300;
    endcase
  end

  function access_ok;
    input [15:0] a;
    input [3:0] size;
    input priv;
    begin
      access_ok = (a[14:0] < (size * `ATA_PART_UNIT)) & (~a[15] | priv);
    end
  endfunction

  // Transmitter.
  reg tx_start;
  reg [6:0] tx_char;
  reg tx_busy;
  reg tx_done;
  reg [10:0] tx_shift;
  reg [3:0] tx_cnt;
  reg [31:0] tx_tmr;

  always @(posedge clk_i) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_cnt <= 4'h0;
      tx_tmr <= 32'h0;
      txd_o <= 1'b1;
    end else begin
      tx_done <= 1'b0;
      if (!tx_busy) begin
        txd_o <= 1'b1;
        if (tx_start) begin
          tx_busy <= 1'b1;
          tx_shift <= {2'b11, ^tx_char, tx_char, 1'b0};
          tx_cnt <= slow ? `ATA_FRAME_BITS_SLOW : `ATA_FRAME_BITS;
          tx_tmr <= 32'h0;
        end
      end else begin
        txd_o <= tx_shift[0];
        if (tx_tmr == bit_div - 32'h1) begin
          tx_tmr <= 32'h0;
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_cnt <= tx_cnt - 4'h1;
          if (tx_cnt == 4'h1) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
          end
        end else begin
          tx_tmr <= tx_tmr + 32'h1;
        end
      end
    end
  end

  // Receiver and break detector.
  reg [1:0] rx_st;
  reg [31:0] rx_tmr;
  reg [3:0] rx_cnt;
  reg [7:0] rx_shift;
  reg rx_done;
  reg rx_bad;
  reg [31:0] brk_cnt;
  reg brk_seen;
  reg brk_pulse;

  always @(posedge clk_i) begin
    if (rst) begin
      rx_st <= RX_IDLE;
      rx_tmr <= 32'h0;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_bad <= 1'b0;
      brk_cnt <= 32'h0;
      brk_seen <= 1'b0;
      brk_pulse <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      brk_pulse <= 1'b0;
      if (rxd_i) begin
        brk_cnt <= 32'h0;
        brk_seen <= 1'b0;
      end else if (!brk_seen) begin
        if (brk_cnt >= BREAK_CYC - 32'h1) begin
          brk_seen <= 1'b1;
          brk_pulse <= 1'b1;
        end else begin
          brk_cnt <= brk_cnt + 32'h1;
        end
      end
      case (rx_st)
        RX_IDLE: begin
          rx_tmr <= 32'h0;
          if (!rxd_i && !brk_seen) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tmr == (bit_div >> 1)) begin
            rx_tmr <= 32'h0;
            rx_cnt <= 4'h0;
            rx_st <= rxd_i ? RX_IDLE : RX_DATA;
          end else begin
            rx_tmr <= rx_tmr + 32'h1;
          end
        end
        RX_DATA: begin
          if (rx_tmr == bit_div - 32'h1) begin
            rx_tmr <= 32'h0;
            rx_shift <= {rxd_i, rx_shift[7:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == 4'h7) begin
              rx_st <= RX_STOP;
            end
          end else begin
            rx_tmr <= rx_tmr + 32'h1;
          end
        end
        default: begin
          if (rx_tmr == bit_div - 32'h1) begin
            rx_tmr <= 32'h0;
            rx_st <= RX_IDLE;
            rx_done <= rxd_i;
            rx_bad <= (^rx_shift) | ~rxd_i;
          end else begin
            rx_tmr <= rx_tmr + 32'h1;
          end
        end
      endcase
    end
  end

  // Adapter control.
  reg [3:0] mode;
  reg [2:0] op;
  reg cmd_pend;
  reg last_req;
  reg tog_pend;
  reg go_local;
  reg sent;
  reg tx_full;
  reg [6:0] tx_data;
  reg rx_valid;
  reg [6:0] rx_data;
  reg [15:0] addr;
  reg [6:0] ctrl_code;
  reg perr;
  reg acc_err;
  reg ctrl_flag;
  reg [31:0] wt;
  reg [6:0] send_char;
  reg [3:0] next_mode;

  wire is_punch = (op == `ATA_OP_PUNCH);
  wire is_read = (op == `ATA_OP_READ) | (op == `ATA_OP_TAPE) | (op == `ATA_OP_RDCTL);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire wb_rd = wb_req & ~wb_we_i;
  wire [6:0] rx_char = rx_shift[6:0];
  wire rx_ctl = (rx_char < 7'h20);
  wire rx_fmt = (rx_char == `ATA_CH_HT) | (rx_char == `ATA_CH_CR);
  wire send_mode = (mode == M1) | (mode == M2) | (mode == M3) | (mode == M6) | (mode == M8) |
    (mode == M9) | (mode == M10) | (mode == M12);

  always @* begin
    send_char = `ATA_CH_SO;
    next_mode = M0;
    case (mode)
      M1: send_char = `ATA_CH_DC4;
      M2: send_char = `ATA_CH_SO;
      M3: begin
        send_char = `ATA_CH_SI;
        next_mode = go_local ? M12 : (is_read ? M8 : M4);
      end
      M6: begin
        send_char = is_punch ? `ATA_CH_DC2 : `ATA_CH_DC1;
        next_mode = is_punch ? M4 : M7;
      end
      M8: begin
        send_char = ((op == `ATA_OP_RDCTL) | reload_needed_flag_i) ? `ATA_CH_L : `ATA_CH_E;
        next_mode = M7;
      end
      M9: begin
        send_char = `ATA_CH_CLOSE;
        next_mode = M10;
      end
      M12: begin
        send_char = `ATA_CH_OPEN;
        next_mode = M13;
      end
      default: begin
        send_char = `ATA_CH_SO;
        next_mode = M0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst) begin
      mode <= M0;
      op <= `ATA_OP_WRITE;
      cmd_pend <= 1'b0;
      last_req <= 1'b0;
      tog_pend <= 1'b0;
      go_local <= 1'b0;
      sent <= 1'b0;
      tx_start <= 1'b0;
      tx_char <= 7'h00;
      tx_full <= 1'b0;
      tx_data <= 7'h00;
      rx_valid <= 1'b0;
      rx_data <= 7'h00;
      addr <= 16'h0000;
      ctrl_code <= 7'h00;
      perr <= 1'b0;
      acc_err <= 1'b0;
      ctrl_flag <= 1'b0;
      wt <= 32'h0;
      local_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      busy_o <= (mode != M0) | cmd_pend;
      if (wt != 32'h0) begin
        wt <= wt - 32'h1;
      end
      // Software side: clears first so that hardware sets below win.
      if (wb_rd && wb_adr_i == `ATA_REG_RXDATA) begin
        rx_valid <= 1'b0;
      end
      if (wb_wr && wb_sel_i[0]) begin
        case (wb_adr_i)
          `ATA_REG_CTRL: begin
            if (wb_dat_i[`ATA_CTRL_START] && mode == M0 && !cmd_pend) begin
              cmd_pend <= 1'b1;
              op <= wb_dat_i[`ATA_CTRL_OP_HI:`ATA_CTRL_OP_LO];
            end
            if (wb_dat_i[`ATA_CTRL_LAST]) begin
              last_req <= 1'b1;
            end
          end
          `ATA_REG_STATUS: begin
            if (wb_dat_i[`ATA_ST_PERR]) perr <= 1'b0;
            if (wb_dat_i[`ATA_ST_ACCERR]) acc_err <= 1'b0;
            if (wb_dat_i[`ATA_ST_CTRLFLAG]) ctrl_flag <= 1'b0;
          end
          `ATA_REG_TXDATA: begin
            tx_data <= wb_dat_i[6:0];
            tx_full <= 1'b1;
          end
          `ATA_REG_ADDR: begin
            addr[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) addr[15:8] <= wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
      if (brk_pulse && mode != M13 && mode != M14) begin
        tog_pend <= 1'b1;
      end
      if (send_mode) begin
        if (!sent && !tx_busy) begin
          tx_start <= 1'b1;
          tx_char <= send_char;
          sent <= 1'b1;
        end else if (sent && tx_done) begin
          sent <= 1'b0;
          mode <= next_mode;
          if (mode == M12) local_o <= 1'b1;
          if (mode == M9) local_o <= 1'b0;
        end
      end
      case (mode)
        M0: begin
          if (tog_pend) begin
            tog_pend <= 1'b0;
            go_local <= 1'b1;
            mode <= M3;
          end else if (cmd_pend) begin
            cmd_pend <= 1'b0;
            go_local <= 1'b0;
            last_req <= 1'b0;
            mode <= (is_punch | (op == `ATA_OP_TAPE)) ? M6 : M3;
          end
        end
        M4: begin
          if (tx_done && op == `ATA_OP_WRCTL) begin
            wt <= write_timeout_switch_i ? WTO_SHORT_CYC : WTO_LONG_CYC;
          end
          if (!tx_busy && !tx_start && !tx_done && wt == 32'h0) begin
            if (tx_full) begin
              tx_full <= 1'b0;
              if (access_ok(addr, partition_size_jumpers_i, privileged_access_jumper_i)) begin
                tx_start <= 1'b1;
                tx_char <= tx_data;
                addr <= addr + 16'h1;
              end else begin
                acc_err <= 1'b1;
              end
            end else if (last_req) begin
              mode <= is_punch ? M1 : M2;
            end
          end
        end
        M7: begin
          if (rx_done) begin
            if (rx_bad) perr <= 1'b1;
            if (rx_ctl && !rx_fmt && !ctrl_char_input_switch_i) begin
              ctrl_code <= rx_char;
              ctrl_flag <= 1'b1;
              if (rx_char == `ATA_CH_DC3) mode <= M2;
            end else if (access_ok(addr, partition_size_jumpers_i, privileged_access_jumper_i)) begin
              rx_data <= (rx_ctl && ctrl_char_input_switch_i) ? (rx_char | `ATA_COL45_BIT) : rx_char;
              rx_valid <= 1'b1;
              addr <= addr + 16'h1;
              if (rx_char == `ATA_CH_CR) mode <= M2;
            end else begin
              acc_err <= 1'b1;
            end
          end else if (last_req) begin
            mode <= M2;
          end
        end
        M13: begin
          if (brk_pulse) mode <= M9;
          else if (rx_done) mode <= M14;
        end
        M14: begin
          if (brk_pulse) mode <= M9;
        end
        default: ;
      endcase
    end
  end

  // Bus answer: one wait state, unmapped addresses read zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_rd) begin
        case (wb_adr_i)
          `ATA_REG_CTRL: wb_dat_o <= {27'h0, last_req, op, cmd_pend};
          `ATA_REG_STATUS: wb_dat_o <= {20'h0, mode, 1'b0, ctrl_flag, acc_err, perr, tx_full, rx_valid,
            local_o, busy_o};
          `ATA_REG_TXDATA: wb_dat_o <= {25'h0, tx_data};
          `ATA_REG_RXDATA: wb_dat_o <= {25'h0, rx_data};
          `ATA_REG_ADDR: wb_dat_o <= {16'h0, addr};
          `ATA_REG_CTRLCODE: wb_dat_o <= {25'h0, ctrl_code};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule // ata_core

/* testbench/ata_core_props.sv */
`timescale 1ns/1ps
module ata_core_props (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic txd_o, // Serial out.
  input wire logic manual_reset_switch_i, // Adapter reset.
  input wire logic local_o, // Local status.
  input wire logic busy_o // Busy.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start_fall;
    $fell(txd_o);
  endsequence
  sequence s_start_hold;
    !txd_o [*8];
  endsequence
  AST_ACK_LAT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  AST_MRESET: assert property (manual_reset_switch_i |=> txd_o && !busy_o && !local_o)
    else $error("manual reset left adapter active");
  AST_START_BIT: assert property (@(posedge clk_i) disable iff (rst_i || manual_reset_switch_i)
    s_start_fall |-> s_start_hold)
    else $error("start bit too short");
  AST_IDLE_LINE: assert property ((!busy_o [*3]) |-> txd_o)
    else $error("line not idle while adapter idle");
  AST_LOCAL_BUSY: assert property ((local_o && $past(local_o)) |-> busy_o)
    else $error("local status outside a mode");
endmodule // ata_core_props
bind ata_core ata_core_props i_ata_core_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o),
  .manual_reset_switch_i(manual_reset_switch_i), .local_o(local_o), .busy_o(busy_o));

/* testbench/ata_term_model.sv */
`timescale 1ns/1ps
module ata_term_model (
  input wire logic clk_i, // Clock.
  input wire logic txd_i, // Line from the adapter.
  input wire logic two_stop_i, // Second stop bit expected.
  input wire logic [7:0] bit_cyc_i, // Clocks per bit.
  output logic rxd_o // Line to the adapter, idle high.
);
  logic [6:0] got[$];
  time at[$];
  logic [8:0] sh;
  int errs;
  initial begin
    rxd_o = 1'b1;
    errs = 0;
  end
  // Frames are decoded at bit centres; a wrong rate, parity or stop shows up as an error.
  always begin
    @(negedge txd_i);
    repeat (bit_cyc_i / 2) @(posedge clk_i);
    if (txd_i === 1'b0) begin
      at.push_back($time);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc_i) @(posedge clk_i);
        sh[i] = txd_i;
      end
      if (^sh[7:0] !== 1'b0 || sh[8] !== 1'b1) errs++;
      if (two_stop_i) begin
        repeat (bit_cyc_i) @(posedge clk_i);
        if (txd_i !== 1'b1) errs++;
      end
      got.push_back(sh[6:0]);
    end
  end
  task automatic send_char(input logic [6:0] ch);
    logic [10:0] fr;
    fr = {2'b11, ^ch, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      rxd_o <= fr[i];
      repeat (bit_cyc_i - 1) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic send_break(input int n);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
endmodule // ata_term_model

/* testbench/ata_core_tb.sv */
`timescale 1ns/1ps
`include "ata_defs.vh"
module ata_core_tb;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, txd_o, rxd, local_o, busy_o;
  logic [7:0] wb_adr, bit_cyc;
  logic [3:0] wb_sel, jumpers;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic ctrl_sw, hi_sw, lo_sw, wto_sw, mrst, priv, reload, two_stop;
  int failures, tests_run, cycles;
  time gap;
  int divs[4] = '{40, 32, 16, 24};
  ata_core #(.DIV_110(40), .DIV_150(32), .DIV_200(24), .DIV_300(16), .BREAK_CYC(600),
    .WTO_LONG_CYC(200), .WTO_SHORT_CYC(100)) i_ata_core (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd), .txd_o(txd_o),
    .ctrl_char_input_switch_i(ctrl_sw), .rate_select_hi_switch_i(hi_sw),
    .rate_select_lo_switch_i(lo_sw), .write_timeout_switch_i(wto_sw), .manual_reset_switch_i(mrst),
    .partition_size_jumpers_i(jumpers), .privileged_access_jumper_i(priv),
    .reload_needed_flag_i(reload), .local_o(local_o), .busy_o(busy_o));
  ata_term_model i_ata_term_model (.clk_i(clk_i), .txd_i(txd_o), .two_stop_i(two_stop),
    .bit_cyc_i(bit_cyc), .rxd_o(rxd));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge clk_i);
    while (busy_o !== 1'b0) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
  endtask
  task automatic wait_got(input int n);
    while (i_ata_term_model.got.size() < n) @(posedge clk_i);
  endtask
  task automatic txq(input int n, input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
    logic [6:0] e[3];
    e = '{a, b, c};
    chk(i_ata_term_model.got.size(), n);
    for (int i = 0; i < n && i < i_ata_term_model.got.size(); i++) chk(i_ata_term_model.got[i], e[i]);
    i_ata_term_model.got.delete();
    i_ata_term_model.at.delete();
  endtask
  task automatic op(input logic [2:0] code, input logic [6:0] ch);
    wr(`ATA_REG_CTRL, {28'h0, code, 1'b1});
    wr(`ATA_REG_TXDATA, {25'h0, ch});
    q = 32'h8;
    while (q[3] !== 1'b0) bus(1'b0, `ATA_REG_STATUS, 32'h0);
    wr(`ATA_REG_CTRL, 32'h10);
    wait_idle();
  endtask
  initial begin
    clk_i = 0; rst_i = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 0; wb_sel = 4'hf; wb_dat = 0;
    ctrl_sw = 0; hi_sw = 0; lo_sw = 0; wto_sw = 0; mrst = 0; jumpers = 4'h1; priv = 0; reload = 0;
    bit_cyc = 8'd40; two_stop = 1; failures = 0; tests_run = 0; cycles = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({local_o, busy_o, txd_o}, 32'h1);
    rdm(`ATA_REG_STATUS, 32'hffffffff, 32'h0);
    rdm(8'h20, 32'hffffffff, 32'h0);
    // The high address byte needs its own select, and no write lands without the low one.
    wr(`ATA_REG_ADDR, 32'h1234);
    wb_sel <= 4'h1;
    wr(`ATA_REG_ADDR, 32'hff56);
    wb_sel <= 4'he;
    wr(`ATA_REG_ADDR, 32'h0);
    wb_sel <= 4'hf;
    rdm(`ATA_REG_ADDR, 32'hffffffff, 32'h1256);
    wr(`ATA_REG_ADDR, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      {hi_sw, lo_sw} <= r[1:0];
      bit_cyc <= divs[r];
      two_stop <= (r == 0);
      op(`ATA_OP_WRITE, 7'h41 + r);
      txq(3, `ATA_CH_SI, 7'h41 + r, `ATA_CH_SO);
    end
    $display("test rates done");
    op(`ATA_OP_PUNCH, 7'h42);
    txq(3, `ATA_CH_DC2, 7'h42, `ATA_CH_DC4);
    for (int s = 0; s < 2; s++) begin
      wto_sw <= s[0];
      op(`ATA_OP_WRCTL, 7'h0a);
      // The pause sits between the control character and the closing code.
      gap = i_ata_term_model.at[2] - i_ata_term_model.at[1];
      chk(gap >= (bit_cyc * 10 + (s ? 100 : 200)) * 8, 32'h1);
      chk(gap < (bit_cyc * 10 + (s ? 140 : 240)) * 8, 32'h1);
      txq(3, `ATA_CH_SI, 7'h0a, `ATA_CH_SO);
    end
    $display("test writes done");
    wr(`ATA_REG_CTRL, {28'h0, `ATA_OP_READ, 1'b1});
    wait_got(2);
    txq(2, `ATA_CH_SI, `ATA_CH_E, 0);
    i_ata_term_model.send_char(7'h07);
    rdm(`ATA_REG_STATUS, 32'h4, 32'h0);
    rdm(`ATA_REG_CTRLCODE, 32'h7f, 32'h07);
    i_ata_term_model.send_char(7'h78);
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h78);
    i_ata_term_model.send_char(`ATA_CH_HT);
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h09);
    i_ata_term_model.send_char(`ATA_CH_CR);
    wait_idle();
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h0d);
    txq(1, `ATA_CH_SO, 0, 0);
    ctrl_sw <= 1'b1;
    wr(`ATA_REG_CTRL, {28'h0, `ATA_OP_RDCTL, 1'b1});
    wait_got(2);
    txq(2, `ATA_CH_SI, `ATA_CH_L, 0);
    i_ata_term_model.send_char(7'h15);
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h55);
    wr(`ATA_REG_ADDR, 32'h03e8);
    i_ata_term_model.send_char(7'h79);
    rdm(`ATA_REG_STATUS, 32'h20, 32'h20);
    wr(`ATA_REG_STATUS, 32'h20);
    jumpers <= 4'h2;
    i_ata_term_model.send_char(7'h7b);
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h7b);
    rdm(`ATA_REG_STATUS, 32'h20, 32'h0);
    wr(`ATA_REG_ADDR, 32'h8000);
    i_ata_term_model.send_char(7'h7c);
    rdm(`ATA_REG_STATUS, 32'h20, 32'h20);
    wr(`ATA_REG_STATUS, 32'h20);
    priv <= 1'b1;
    i_ata_term_model.send_char(7'h7d);
    rdm(`ATA_REG_RXDATA, 32'hffffffff, 32'h7d);
    rdm(`ATA_REG_ADDR, 32'hffff, 32'h8001);
    wr(`ATA_REG_CTRL, 32'h10);
    wait_idle();
    txq(1, `ATA_CH_SO, 0, 0);
    ctrl_sw <= 1'b0;
    wr(`ATA_REG_ADDR, 32'h0);
    wr(`ATA_REG_CTRL, {28'h0, `ATA_OP_TAPE, 1'b1});
    wait_got(1);
    i_ata_term_model.send_char(`ATA_CH_DC3);
    wait_idle();
    txq(2, `ATA_CH_DC1, `ATA_CH_SO, 0);
    reload <= 1'b1;
    wr(`ATA_REG_CTRL, {28'h0, `ATA_OP_READ, 1'b1});
    wait_got(2);
    txq(2, `ATA_CH_SI, `ATA_CH_L, 0);
    reload <= 1'b0;
    wr(`ATA_REG_CTRL, 32'h10);
    wait_idle();
    txq(1, `ATA_CH_SO, 0, 0);
    $display("test reads done");
    i_ata_term_model.send_break(700);
    wait_got(2);
    repeat (50) @(posedge clk_i);
    txq(2, `ATA_CH_SI, `ATA_CH_OPEN, 0);
    chk(local_o, 32'h1);
    i_ata_term_model.send_char(7'h7a);
    rdm(`ATA_REG_STATUS, 32'h4, 32'h0);
    i_ata_term_model.send_break(700);
    wait_idle();
    txq(2, `ATA_CH_CLOSE, `ATA_CH_SO, 0);
    chk(local_o, 32'h0);
    chk(i_ata_term_model.errs, 32'h0);
    $display("test local done");
    wr(`ATA_REG_CTRL, {28'h0, `ATA_OP_WRITE, 1'b1});
    repeat (20) @(posedge clk_i);
    mrst <= 1'b1;
    repeat (2) @(posedge clk_i);
    mrst <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({busy_o, txd_o}, 32'h1);
    rdm(`ATA_REG_STATUS, 32'hf01, 32'h0);
    $display("test manual reset done");
    conclude();
  end
endmodule // ata_core_tb
